// ---- logic/iss_pkg.sv ----
/*
 * Package for the interrupt source selector: register byte addresses,
 * selector field layout, reset codes, source codes and bus responses.
 * Assumes a 32-bit AXI4-Lite register bus and a 32-entry source vector.
 */
package iss_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [31:0] ISS_ADDR_SELECT_HIGH = 32'h019c_0000;
    localparam logic [31:0] ISS_ADDR_SELECT_LOW  = 32'h019c_0004;

    // ------------------------------------------------------------------
    // Field layout: six 5-bit fields, bits 15 and 31 unused
    // ------------------------------------------------------------------
    localparam int ISS_SEL_W       = 5;
    localparam int ISS_FIELDS      = 6;
    localparam int ISS_NUM_SRC     = 32;
    localparam int ISS_FIELD_LSB [ISS_FIELDS] = '{0, 5, 10, 16, 21, 26};
    localparam logic [31:0] ISS_USED_MASK = 32'h7fff_7fff;

    // ------------------------------------------------------------------
    // Reset values (lines 4..9 low, 10..15 high)
    // ------------------------------------------------------------------
    localparam logic [31:0] ISS_RESET_LOW  = 32'h2507_18a4;
    localparam logic [31:0] ISS_RESET_HIGH = 32'h0820_2d43;

    // ------------------------------------------------------------------
    // Source codes
    // ------------------------------------------------------------------
    localparam logic [4:0] ISS_SRC_HOST      = 5'h00;
    localparam logic [4:0] ISS_SRC_TIMER0    = 5'h01;
    localparam logic [4:0] ISS_SRC_TIMER1    = 5'h02;
    localparam logic [4:0] ISS_SRC_MEMIF_A   = 5'h03;
    localparam logic [4:0] ISS_SRC_EXT4      = 5'h04;
    localparam logic [4:0] ISS_SRC_DMA       = 5'h08;
    localparam logic [4:0] ISS_SRC_EMU_DMA   = 5'h09;
    localparam logic [4:0] ISS_SRC_EMU_RX    = 5'h0a;
    localparam logic [4:0] ISS_SRC_EMU_TX    = 5'h0b;
    localparam logic [4:0] ISS_SRC_SP0_TX    = 5'h0c;
    localparam logic [4:0] ISS_SRC_SP0_RX    = 5'h0d;
    localparam logic [4:0] ISS_SRC_SP1_TX    = 5'h0e;
    localparam logic [4:0] ISS_SRC_SP1_RX    = 5'h0f;
    localparam logic [4:0] ISS_SRC_GPIO0     = 5'h10;
    localparam logic [4:0] ISS_SRC_SP2_TX    = 5'h11;
    localparam logic [4:0] ISS_SRC_SP2_RX    = 5'h12;
    localparam logic [4:0] ISS_SRC_TIMER2    = 5'h13;
    localparam logic [4:0] ISS_SRC_MEMIF_B   = 5'h14;
    localparam logic [4:0] ISS_SRC_CELL      = 5'h17;
    localparam logic [4:0] ISS_SRC_VITERBI   = 5'h1e;
    localparam logic [4:0] ISS_SRC_TURBO     = 5'h1f;

    // ------------------------------------------------------------------
    // Bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0] ISS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] ISS_RESP_SLVERR = 2'h2;

endpackage : iss_pkg

// ---- logic/iss_selector.sv ----
/*
 * Interrupt source selector: routes 32 peripheral event codes onto the
 * maskable core interrupt lines 4..15 under two AXI4-Lite registers.
 * Assumes all event inputs are synchronous to aclk except the four
 * external interrupt pins, which are synchronised here.
 */
// Operation
// - Lines 0..3 come straight from reset, NMI and two reserved zeros.
// - Lines 4..15 each take their source from their own selector field.
// - Low register fields for lines 4..9 at 4:0,9:5,14:10,20:16,25:21,30:26.
// - High register holds lines 10..15 in the same field layout.
// - Lines 4..9 reset to codes 4,5,6,7,8,9.
// - Lines 10..15 reset to codes 3,10,11,0,1,2.
// - Codes 0..7: host, timer0, timer1, memif A, external pins 4..7.
// - Codes 8..11: DMA done, debug DMA, exchange receive, exchange transmit.
// - Codes 12..20: serial ports, GPIO event 0, timer 2, memif B.
// - Codes 23, 30, 31: cell interface, Viterbi and turbo coprocessors.
// - External pins 4..7 serve as interrupt inputs after reset.
// - Core treats line 0 as highest priority, line 15 lowest.
// - High register at 0x019c0000, low register at 0x019c0004.
`timescale 1ns/1ps

module iss_selector (
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Fixed sources
    input  wire logic        reset_event,
    input  wire logic        nmi_event,
    // Peripheral event sources
    input  wire logic        host_to_core_irq,
    input  wire logic        timer_zero_irq,
    input  wire logic        timer_one_irq,
    input  wire logic        timer_two_irq,
    input  wire logic        memif_a_refresh_timer_irq,
    input  wire logic        memif_b_refresh_timer_irq,
    input  wire logic [3:0]  external_irq_pins,
    input  wire logic        dma_completion_irq,
    input  wire logic        emulation_debug_dma_event,
    input  wire logic        emulation_exchange_rx,
    input  wire logic        emulation_exchange_tx,
    input  wire logic        serial_port0_tx_irq,
    input  wire logic        serial_port0_rx_irq,
    input  wire logic        serial_port1_tx_irq,
    input  wire logic        serial_port1_rx_irq,
    input  wire logic        serial_port2_tx_irq,
    input  wire logic        serial_port2_rx_irq,
    input  wire logic        gpio_event_zero,
    input  wire logic        cell_interface_irq,
    input  wire logic        viterbi_coproc_irq,
    input  wire logic        turbo_coproc_irq,
    // Core interrupt lines, 0 highest priority
    output logic [15:0]      core_irq
);

    // ------------------------------------------------------------------
    // Selector registers
    // ------------------------------------------------------------------
    logic [31:0] select_low_reg;
    logic [31:0] select_high_reg;

    // Field of a line within its register
    function automatic logic [4:0] iss_field(input logic [31:0] r,
                                             input int          idx);
        iss_field = r[iss_pkg::ISS_FIELD_LSB[idx] +: iss_pkg::ISS_SEL_W];
    endfunction : iss_field

    // Merge a write under byte strobes, unused bits kept at zero
    function automatic logic [31:0] iss_merge(input logic [31:0] old,
                                              input logic [31:0] data,
                                              input logic [3:0]  strb);
        logic [31:0] m;
        m = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                m[b*8 +: 8] = data[b*8 +: 8];
            end
        end
        iss_merge = m & iss_pkg::ISS_USED_MASK;
    endfunction : iss_merge

    // ------------------------------------------------------------------
    // External pin synchroniser
    // ------------------------------------------------------------------
    logic [3:0] ext_meta_reg;
    logic [3:0] ext_sync_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_meta_reg <= 4'h0;
            ext_sync_reg <= 4'h0;
        end else begin
            ext_meta_reg <= external_irq_pins;
            ext_sync_reg <= ext_meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // Source vector
    // ------------------------------------------------------------------
    logic [31:0] src_vec;

    always_comb begin
        src_vec = 32'h0000_0000;
        src_vec[iss_pkg::ISS_SRC_HOST]    = host_to_core_irq;
        src_vec[iss_pkg::ISS_SRC_TIMER0]  = timer_zero_irq;
        src_vec[iss_pkg::ISS_SRC_TIMER1]  = timer_one_irq;
        src_vec[iss_pkg::ISS_SRC_MEMIF_A] = memif_a_refresh_timer_irq;
        for (int p = 0; p < 4; p++) begin
            src_vec[int'(iss_pkg::ISS_SRC_EXT4) + p] = ext_sync_reg[p];
        end
        src_vec[iss_pkg::ISS_SRC_DMA]     = dma_completion_irq;
        src_vec[iss_pkg::ISS_SRC_EMU_DMA] = emulation_debug_dma_event;
        src_vec[iss_pkg::ISS_SRC_EMU_RX]  = emulation_exchange_rx;
        src_vec[iss_pkg::ISS_SRC_EMU_TX]  = emulation_exchange_tx;
        src_vec[iss_pkg::ISS_SRC_SP0_TX]  = serial_port0_tx_irq;
        src_vec[iss_pkg::ISS_SRC_SP0_RX]  = serial_port0_rx_irq;
        src_vec[iss_pkg::ISS_SRC_SP1_TX]  = serial_port1_tx_irq;
        src_vec[iss_pkg::ISS_SRC_SP1_RX]  = serial_port1_rx_irq;
        src_vec[iss_pkg::ISS_SRC_GPIO0]   = gpio_event_zero;
        src_vec[iss_pkg::ISS_SRC_SP2_TX]  = serial_port2_tx_irq;
        src_vec[iss_pkg::ISS_SRC_SP2_RX]  = serial_port2_rx_irq;
        src_vec[iss_pkg::ISS_SRC_TIMER2]  = timer_two_irq;
        src_vec[iss_pkg::ISS_SRC_MEMIF_B] = memif_b_refresh_timer_irq;
        src_vec[iss_pkg::ISS_SRC_CELL]    = cell_interface_irq;
        src_vec[iss_pkg::ISS_SRC_VITERBI] = viterbi_coproc_irq;
        src_vec[iss_pkg::ISS_SRC_TURBO]   = turbo_coproc_irq;
    end

    // ------------------------------------------------------------------
    // Core interrupt lines
    // ------------------------------------------------------------------
    logic [15:0] core_irq_next;

    always_comb begin
        core_irq_next    = 16'h0000;
        core_irq_next[0] = reset_event;
        core_irq_next[1] = nmi_event;
        for (int f = 0; f < iss_pkg::ISS_FIELDS; f++) begin
            core_irq_next[4 + f]  =
                src_vec[iss_field(select_low_reg, f)];
            core_irq_next[10 + f] =
                src_vec[iss_field(select_high_reg, f)];
        end
    end

    // Line order carries priority; core resolves it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            core_irq <= 16'h0000;
        end else begin
            core_irq <= core_irq_next;
        end
    end

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    logic        aw_held_reg;
    logic [31:0] aw_addr_reg;
    logic        w_held_reg;
    logic [31:0] w_data_reg;
    logic [3:0]  w_strb_reg;
    logic        do_write;
    logic        wr_hit_low;
    logic        wr_hit_high;

    assign do_write    = aw_held_reg && w_held_reg && !s_axi_bvalid;
    assign wr_hit_low  = aw_addr_reg[31:2]
                         == iss_pkg::ISS_ADDR_SELECT_LOW[31:2];
    assign wr_hit_high = aw_addr_reg[31:2]
                         == iss_pkg::ISS_ADDR_SELECT_HIGH[31:2];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg   <= 1'b0;
            aw_addr_reg   <= 32'h0000_0000;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held_reg   <= 1'b0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg   <= 1'b1;
            aw_addr_reg   <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg   <= 1'b0;
            w_data_reg   <= 32'h0000_0000;
            w_strb_reg   <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held_reg   <= 1'b0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg   <= 1'b1;
            w_data_reg   <= s_axi_wdata;
            w_strb_reg   <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_wready <= !w_held_reg && !s_axi_bvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= iss_pkg::ISS_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_hit_low || wr_hit_high)
                            ? iss_pkg::ISS_RESP_OKAY
                            : iss_pkg::ISS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Selector register update
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            select_low_reg <= iss_pkg::ISS_RESET_LOW;
        end else if (do_write && wr_hit_low) begin
            select_low_reg <= iss_merge(select_low_reg, w_data_reg,
                                        w_strb_reg);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            select_high_reg <= iss_pkg::ISS_RESET_HIGH;
        end else if (do_write && wr_hit_high) begin
            select_high_reg <= iss_merge(select_high_reg, w_data_reg,
                                         w_strb_reg);
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
        end else begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid
                             && s_axi_arvalid;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= iss_pkg::ISS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            if (s_axi_araddr[31:2]
                == iss_pkg::ISS_ADDR_SELECT_LOW[31:2]) begin
                s_axi_rdata <= select_low_reg;
                s_axi_rresp <= iss_pkg::ISS_RESP_OKAY;
            end else if (s_axi_araddr[31:2]
                         == iss_pkg::ISS_ADDR_SELECT_HIGH[31:2]) begin
                s_axi_rdata <= select_high_reg;
                s_axi_rresp <= iss_pkg::ISS_RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= iss_pkg::ISS_RESP_SLVERR;
            end
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule : iss_selector

// ---- testbench/interrupt_source_selector_tb.sv ----
/* Self-checking bench for the interrupt source selector.
   Assumes iss_pkg, iss_selector, iss_props and iss_event_src. */
`timescale 1ns/1ps
module interrupt_source_selector_tb;
    localparam logic [31:0] VMASK = 32'hc09f_ffff;
    localparam logic [31:0] LO = iss_pkg::ISS_ADDR_SELECT_LOW;
    localparam logic [31:0] HI = iss_pkg::ISS_ADDR_SELECT_HIGH;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0, look = 0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic        s_axi_arready, s_axi_rvalid, reset_event = 0, nmi_event = 0;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, code_act = '0;
    logic [15:0] core_irq;
    logic [3:0]  external_irq_pins;
    logic host_to_core_irq, timer_zero_irq, timer_one_irq, timer_two_irq,
        memif_a_refresh_timer_irq, memif_b_refresh_timer_irq,
        dma_completion_irq, emulation_debug_dma_event, emulation_exchange_rx,
        emulation_exchange_tx, serial_port0_tx_irq, serial_port0_rx_irq,
        serial_port1_tx_irq, serial_port1_rx_irq, serial_port2_tx_irq,
        serial_port2_rx_irq, gpio_event_zero, cell_interface_irq,
        viterbi_coproc_irq, turbo_coproc_irq;
    logic [33:0] qb[$], qr[$], qi[$];
    logic [4:0]  sel [16] = '{5'h00, 5'h00, 5'h00, 5'h00, 5'h04, 5'h05,
        5'h06, 5'h07, 5'h08, 5'h09, 5'h03, 5'h0a, 5'h0b, 5'h00, 5'h01, 5'h02};
    int          err_count = 0, samples_checked = 0, cyc = 0;

    iss_selector DUT (.*);
    iss_event_src u_src (.*);

    initial forever #5 aclk = ~aclk;
    // --------------------------------------------------------------
    // Checking and closing
    // --------------------------------------------------------------
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("mismatches %0d checks %0d", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : conclude
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 8000) begin
            err_count++;
            conclude();
        end
        if (s_axi_bvalid && s_axi_bready)
            check({32'h0, s_axi_bresp}, qb.pop_front());
        if (s_axi_rvalid && s_axi_rready)
            check({s_axi_rdata, s_axi_rresp}, qr.pop_front());
    end
    always @(negedge aclk) if (look) check({18'h0, core_irq}, qi.pop_front());
    // --------------------------------------------------------------
    // Stimulus
    // --------------------------------------------------------------
    function automatic logic [31:0] pack(input int base);
        logic [31:0] v;
        v = '0;
        for (int k = 0; k < 6; k++)
            v[iss_pkg::ISS_FIELD_LSB[k] +: 5] = sel[base + k];
        return v;
    endfunction : pack
    function automatic logic [4:0] nxt(input int x);
        int c;
        c = x % 32;
        while (!VMASK[c]) c = (c + 1) % 32;
        return c[4:0];
    endfunction : nxt
    task automatic wr(input logic [31:0] a, d, input logic [1:0] r);
        bit aw, w;
        aw = 0;
        w = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        qb.push_back({32'h0, r});
        while (!(aw && w)) begin
            @(posedge aclk);
            if (!aw && s_axi_awready) begin
                aw = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w && s_axi_wready) begin
                w = 1;
                s_axi_wvalid <= 1'b0;
            end
        end
        // Late bready lets the slave show it holds its answer
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b1;
        do @(posedge aclk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr
    task automatic rd(input logic [31:0] a, d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        qr.push_back({d, r});
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b1;
        do @(posedge aclk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd
    task automatic route(input logic [31:0] act);
        logic [15:0] e;
        code_act <= act & VMASK;
        reset_event <= act[21];
        nmi_event <= act[22];
        repeat (4) @(posedge aclk);
        e = {14'h0, nmi_event, reset_event};
        for (int n = 4; n < 16; n++) e[n] = code_act[sel[n]];
        qi.push_back({18'h0, e});
        look <= 1'b1;
        @(posedge aclk);
        look <= 1'b0;
    endtask : route
    initial begin
        logic [31:0] seed;
        seed = $urandom(32'hfdc1);
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(LO, pack(4), 2'h0);
        rd(HI, pack(10), 2'h0);
        for (int c = 0; c < 32; c++) route(32'h1 << c);
        for (int i = 0; i < 3; i++) begin
            for (int n = 4; n < 16; n++) sel[n] = nxt(i * 12 + n);
            wr(LO, pack(4), 2'h0);
            wr(HI, pack(10), 2'h0);
            rd(LO, pack(4), 2'h0);
            rd(HI, pack(10), 2'h0);
            for (int c = 0; c < 32; c++) route(32'h1 << c);
            repeat (8) route($urandom);
        end
        wr(32'h019c_0008, 32'hffff_ffff, 2'h2);
        rd(32'h019c_0008, 32'h0, 2'h2);
        rd(LO, pack(4), 2'h0);
        // Only byte lane 1 written: lanes 0, 2 and 3 keep their bits
        s_axi_wstrb <= 4'h2;
        wr(LO, 32'h0, 2'h0);
        s_axi_wstrb <= 4'hf;
        rd(LO, pack(4) & 32'hffff_00ff, 2'h0);
        conclude();
    end
endmodule : interrupt_source_selector_tb

bind iss_selector iss_props u_props (
    .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .reset_event, .nmi_event,
    .host_to_core_irq, .timer_zero_irq, .memif_a_refresh_timer_irq,
    .core_irq
);

// ---- testbench/iss_event_src.sv ----
/* Peripheral event source model for the selector bench.
   Assumes code_act bit n asserts the source of selector code n. */
`timescale 1ns/1ps
module iss_event_src (
    // Active source codes
    input  wire logic [31:0] code_act,
    // Event lines
    output logic             host_to_core_irq,
    output logic             timer_zero_irq,
    output logic             timer_one_irq,
    output logic             timer_two_irq,
    output logic             memif_a_refresh_timer_irq,
    output logic             memif_b_refresh_timer_irq,
    output logic [3:0]       external_irq_pins,
    output logic             dma_completion_irq,
    output logic             emulation_debug_dma_event,
    output logic             emulation_exchange_rx,
    output logic             emulation_exchange_tx,
    output logic             serial_port0_tx_irq,
    output logic             serial_port0_rx_irq,
    output logic             serial_port1_tx_irq,
    output logic             serial_port1_rx_irq,
    output logic             serial_port2_tx_irq,
    output logic             serial_port2_rx_irq,
    output logic             gpio_event_zero,
    output logic             cell_interface_irq,
    output logic             viterbi_coproc_irq,
    output logic             turbo_coproc_irq
);
    // Pins move off the clock edge, as real external inputs do
    initial external_irq_pins = 4'h0;
    always @(code_act) external_irq_pins <= #3 code_act[7:4];
    assign {memif_a_refresh_timer_irq, timer_one_irq, timer_zero_irq,
            host_to_core_irq} = code_act[3:0];
    assign {memif_b_refresh_timer_irq, timer_two_irq, serial_port2_rx_irq,
            serial_port2_tx_irq, gpio_event_zero, serial_port1_rx_irq,
            serial_port1_tx_irq, serial_port0_rx_irq, serial_port0_tx_irq,
            emulation_exchange_tx, emulation_exchange_rx,
            emulation_debug_dma_event,
            dma_completion_irq} = code_act[20:8];
    assign cell_interface_irq = code_act[23];
    assign {turbo_coproc_irq, viterbi_coproc_irq} = code_act[31:30];
endmodule : iss_event_src

// ---- testbench/iss_props.sv ----
/* Port checker for the interrupt source selector.
   Assumes binding onto iss_selector, one clock, synchronous reset. */
`timescale 1ns/1ps
module iss_props (
    // Clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // Register bus
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // Sources and core lines
    input wire logic        reset_event,
    input wire logic        nmi_event,
    input wire logic        host_to_core_irq,
    input wire logic        timer_zero_irq,
    input wire logic        memif_a_refresh_timer_irq,
    input wire logic [15:0] core_irq
);
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    property p_fixed_reset;
        $past(aresetn) |-> core_irq[0] == $past(reset_event);
    endproperty
    a_fixed_reset: assert property (p_fixed_reset)
        else $error("line 0 not following reset source");
    property p_fixed_nmi;
        $past(aresetn) |-> core_irq[1] == $past(nmi_event);
    endproperty
    a_fixed_nmi: assert property (p_fixed_nmi)
        else $error("line 1 not following nmi source");
    property p_spare;
        core_irq[3:2] == 2'h0;
    endproperty
    a_spare: assert property (p_spare)
        else $error("lines 2 and 3 not idle");
    property p_reset_route;
        $past(aresetn) && !$past(aresetn, 2) |->
            core_irq[13] == $past(host_to_core_irq) &&
            core_irq[14] == $past(timer_zero_irq) &&
            core_irq[10] == $past(memif_a_refresh_timer_irq);
    endproperty
    a_reset_route: assert property (p_reset_route)
        else $error("default routing wrong after reset");
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read answer late");
    property p_rdata_hold;
        s_axi_rvalid && !s_axi_rready |=>
            s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold)
        else $error("read answer not held");
    property p_bresp_hold;
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
    endproperty
    a_bresp_hold: assert property (p_bresp_hold)
        else $error("write answer not held");
    property p_unused_bits;
        s_axi_rvalid |-> s_axi_rdata[15] == 1'b0 && s_axi_rdata[31] == 1'b0;
    endproperty
    a_unused_bits: assert property (p_unused_bits)
        else $error("unused register bit read as one");

    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
    c_line4: cover property ($rose(core_irq[4]));
endmodule : iss_props
